// >>> rtl/brf_unit.sv
// byte rotate and fill execution unit with operand file and control port
`timescale 1ns/10ps
`default_nettype none

module brf_unit
    import brf_pkg::*;
#(
    parameter int BANK_W = 4,
    parameter logic [BANK_W-1:0] SHORTCUT_BANK = '0
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_write,
    input wire logic bus_read,
    output logic [31:0] bus_rdata,
    output logic instr_done,
    output logic instr_illegal,
    output logic [7:0] accumulator,
    output brf_flags_t flags,
    output logic [7:0] result
);

    localparam int ADDR_W = BANK_W + 8;
    localparam int DEPTH = 1 << ADDR_W;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0] file_mem [0:DEPTH-1];
    logic [BANK_W-1:0] bank_select_register;
    logic [ADDR_W-1:0] mem_ptr;
    logic [15:0] exec_count;

    brf_dec_t dec;
    logic fire;
    logic rotate;
    logic to_file;
    logic [ADDR_W-1:0] opnd_addr;
    logic [7:0] opnd;
    logic [7:0] next_result;
    logic bus_wr_acc;
    logic bus_wr_flags;

    // ------------------------------------------------------------------
    // decode and operand fetch
    // ------------------------------------------------------------------
    assign dec = brf_decode(instr_word);
    assign fire = instr_valid && (dec.opc != BRF_OPC_NONE);
    assign rotate = fire && (dec.opc != BRF_OPC_FILL_ONES);
    // fill ones carries no target bit, so it always lands in the file
    assign to_file = dec.to_file || (dec.opc == BRF_OPC_FILL_ONES);

    always_comb begin
        if (dec.banked) begin
            opnd_addr = {bank_select_register, dec.index};
        end else begin
            opnd_addr = {SHORTCUT_BANK, dec.index};
        end
    end

    assign opnd = file_mem[opnd_addr];
    assign bus_wr_acc = bus_write && (bus_addr == BRF_ADDR_ACC);
    assign bus_wr_flags = bus_write && (bus_addr == BRF_ADDR_FLAGS);

    // ------------------------------------------------------------------
    // data path
    // ------------------------------------------------------------------
    always_comb begin
        case (dec.opc)
            BRF_OPC_ROT_LEFT_PLAIN: begin
                next_result = {opnd[6:0], opnd[7]};
            end
            BRF_OPC_ROT_RIGHT_CARRY: begin
                next_result = {flags.link, opnd[7:1]};
            end
            BRF_OPC_ROT_RIGHT_PLAIN: begin
                next_result = {opnd[0], opnd[7:1]};
            end
            BRF_OPC_FILL_ONES: begin
                next_result = BRF_FILL_VALUE;
            end
            default: begin
                next_result = opnd;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // operand file: one write port, the instruction beats the bus
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset_n && fire && to_file) begin
            file_mem[opnd_addr] <= next_result;
        end else if (reset_n && bus_write && (bus_addr == BRF_ADDR_DATA)) begin
            file_mem[mem_ptr] <= bus_wdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // accumulator
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            accumulator <= BRF_ACC_RESET;
        end else if (fire && !to_file) begin
            accumulator <= next_result;
        end else if (bus_wr_acc) begin
            accumulator <= bus_wdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // flags: hardware update wins over a software write in the same cycle
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            flags <= BRF_FLAGS_RESET;
        end else if (rotate) begin
            flags.top <= next_result[7];
            flags.zero <= (next_result == BRF_ZERO_BYTE);
            if (dec.opc == BRF_OPC_ROT_RIGHT_CARRY) begin
                flags.link <= opnd[0];
            end
        end else if (bus_wr_flags) begin
            flags <= bus_wdata[2:0];
        end
    end

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            bank_select_register <= '0;
        end else if (bus_write && (bus_addr == BRF_ADDR_BANK)) begin
            bank_select_register <= bus_wdata[BANK_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            mem_ptr <= '0;
        end else if (bus_write && (bus_addr == BRF_ADDR_PTR)) begin
            mem_ptr <= bus_wdata[ADDR_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // completion, result and counters
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            instr_done <= 1'b0;
            instr_illegal <= 1'b0;
            result <= BRF_RESULT_RESET;
        end else begin
            instr_done <= fire;
            instr_illegal <= instr_valid && !fire;
            if (fire) begin
                result <= next_result;
            end
        end
    end

    // wraps silently; software reads differences only
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            exec_count <= BRF_COUNT_RESET;
        end else if (fire) begin
            exec_count <= exec_count + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // read data: valid only in the cycle after the strobe
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            bus_rdata <= 32'h0000_0000;
        end else if (bus_read) begin
            case (bus_addr)
                BRF_ADDR_ACC: bus_rdata <= {24'h00_0000, accumulator};
                BRF_ADDR_BANK: bus_rdata <= 32'(bank_select_register);
                BRF_ADDR_FLAGS: bus_rdata <= {29'h0000_0000, flags};
                BRF_ADDR_PTR: bus_rdata <= 32'(mem_ptr);
                BRF_ADDR_DATA: bus_rdata <= {24'h00_0000, file_mem[mem_ptr]};
                BRF_ADDR_COUNT: bus_rdata <= {16'h0000, exec_count};
                BRF_ADDR_RESULT: bus_rdata <= {24'h00_0000, result};
                default: bus_rdata <= 32'h0000_0000;
            endcase
        end else begin
            bus_rdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking brf_cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    rot_left_plain_a: assert property (
        fire && dec.opc == BRF_OPC_ROT_LEFT_PLAIN
        |=> result == {$past(opnd[6:0]), $past(opnd[7])} && $stable(flags.link))
        else $error("rotate left plain result or link wrong");

    rot_right_carry_a: assert property (
        fire && dec.opc == BRF_OPC_ROT_RIGHT_CARRY
        |=> flags.link == $past(opnd[0]) && result[7] == $past(flags.link)
            && result[6:0] == $past(opnd[7:1]))
        else $error("rotate right through link wrong");

    rot_right_plain_a: assert property (
        fire && dec.opc == BRF_OPC_ROT_RIGHT_PLAIN
        |=> result == {$past(opnd[0]), $past(opnd[7:1])} && $stable(flags.link))
        else $error("rotate right plain wrong");

    fill_ones_a: assert property (
        fire && dec.opc == BRF_OPC_FILL_ONES && !bus_wr_flags
        |=> file_mem[$past(opnd_addr)] == BRF_FILL_VALUE && $stable(flags))
        else $error("fill ones did not write all ones or touched flags");

    // a same-cycle software write to the byte is not a disturbance by the unit
    dest_accumulator_a: assert property (
        rotate && !to_file && !(bus_write && bus_addr == BRF_ADDR_DATA)
        |=> accumulator == result && file_mem[$past(opnd_addr)] == $past(opnd))
        else $error("accumulator target wrong or operand disturbed");

    dest_file_a: assert property (
        rotate && to_file && !bus_wr_acc
        |=> file_mem[$past(opnd_addr)] == result && $stable(accumulator))
        else $error("file target wrong or accumulator disturbed");

    shortcut_bank_a: assert property (
        fire && !dec.banked |-> opnd_addr[ADDR_W-1:8] == SHORTCUT_BANK)
        else $error("shortcut bank not used");

    banked_addr_a: assert property (
        fire && dec.banked |-> opnd_addr == {bank_select_register, instr_word[7:0]})
        else $error("bank select address wrong");

    flag_update_a: assert property (
        rotate |=> flags.top == result[7] && flags.zero == (result == BRF_ZERO_BYTE))
        else $error("top or zero flag wrong");

    done_pulse_a: assert property (
        fire |=> instr_done && result == $past(next_result))
        else $error("done pulse missing");

    done_cause_a: assert property (
        instr_done |-> $past(fire))
        else $error("done without instruction");

    read_timing_a: assert property (
        !bus_read |=> bus_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");

    illegal_refused_a: assert property (
        instr_valid && !fire |=> instr_illegal && !instr_done && $stable(result))
        else $error("unknown opcode not refused cleanly");

    fill_keeps_acc_a: assert property (
        fire && dec.opc == BRF_OPC_FILL_ONES && !bus_wr_acc
        |=> result == BRF_FILL_VALUE && $stable(accumulator))
        else $error("fill ones touched the accumulator");

    // bus side, plus the execution count: software writes and reads land exactly as the port promises
    flags_write_a: assert property (
        bus_wr_flags && !rotate |=> flags == $past(bus_wdata[2:0]))
        else $error("software flag write lost");

    count_step_a: assert property (
        fire |=> exec_count == $past(exec_count) + 16'h0001)
        else $error("execution count did not step");

    read_acc_a: assert property (
        bus_read && bus_addr == BRF_ADDR_ACC
        |=> bus_rdata == {24'h00_0000, $past(accumulator)})
        else $error("accumulator read data wrong");

    rrc_zero_c: cover property (
        fire && dec.opc == BRF_OPC_ROT_RIGHT_CARRY ##1 flags.zero);
    back_to_back_c: cover property (fire ##1 fire ##1 instr_done);
    banked_fill_c: cover property (fire && dec.banked && dec.opc == BRF_OPC_FILL_ONES);
    acc_target_c: cover property (rotate && !to_file && bus_read);
    illegal_c: cover property (instr_valid && !fire);

endmodule

`default_nettype wire

// >>> rtl/brf_pkg.sv
// constants, types and decode helper for the byte rotate and fill unit
package brf_pkg;

    // ------------------------------------------------------------------
    // register map of the control port (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] BRF_ADDR_ACC = 8'h00;
    localparam logic [7:0] BRF_ADDR_BANK = 8'h04;
    localparam logic [7:0] BRF_ADDR_FLAGS = 8'h08;
    localparam logic [7:0] BRF_ADDR_PTR = 8'h0c;
    localparam logic [7:0] BRF_ADDR_DATA = 8'h10;
    localparam logic [7:0] BRF_ADDR_COUNT = 8'h14;
    localparam logic [7:0] BRF_ADDR_RESULT = 8'h18;

    // ------------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------------
    localparam logic [7:0] BRF_ACC_RESET = 8'h00;
    localparam logic [15:0] BRF_COUNT_RESET = 16'h0000;
    localparam logic [7:0] BRF_RESULT_RESET = 8'h00;

    // ------------------------------------------------------------------
    // instruction encodings and constants
    // ------------------------------------------------------------------
    localparam logic [5:0] BRF_OP_ROT_LEFT_PLAIN = 6'h11;
    localparam logic [5:0] BRF_OP_ROT_RIGHT_CARRY = 6'h0c;
    localparam logic [5:0] BRF_OP_ROT_RIGHT_PLAIN = 6'h10;
    localparam logic [6:0] BRF_OP_FILL_ONES = 7'h34;
    localparam logic [7:0] BRF_FILL_VALUE = 8'hff;
    localparam logic [7:0] BRF_ZERO_BYTE = 8'h00;
    localparam int BRF_EXEC_CYCLES = 1;

    typedef enum logic [2:0] {
        BRF_OPC_NONE = 3'h0,
        BRF_OPC_ROT_LEFT_PLAIN = 3'h1,
        BRF_OPC_ROT_RIGHT_CARRY = 3'h2,
        BRF_OPC_ROT_RIGHT_PLAIN = 3'h3,
        BRF_OPC_FILL_ONES = 3'h4
    } brf_opc_t;

    typedef struct packed {
        brf_opc_t opc;
        logic to_file;
        logic banked;
        logic [7:0] index;
    } brf_dec_t;

    // bit 0 link, bit 1 zero, bit 2 top
    typedef struct packed {
        logic top;
        logic zero;
        logic link;
    } brf_flags_t;

    localparam brf_flags_t BRF_FLAGS_RESET = 3'h0;

    function automatic brf_dec_t brf_decode(input logic [15:0] word);
        brf_dec_t d;
        d.opc = BRF_OPC_NONE;
        d.to_file = word[9];
        d.banked = word[8];
        d.index = word[7:0];
        if (word[15:10] == BRF_OP_ROT_LEFT_PLAIN) begin
            d.opc = BRF_OPC_ROT_LEFT_PLAIN;
        end else if (word[15:10] == BRF_OP_ROT_RIGHT_CARRY) begin
            d.opc = BRF_OPC_ROT_RIGHT_CARRY;
        end else if (word[15:10] == BRF_OP_ROT_RIGHT_PLAIN) begin
            d.opc = BRF_OPC_ROT_RIGHT_PLAIN;
        end else if (word[15:9] == BRF_OP_FILL_ONES) begin
            d.opc = BRF_OPC_FILL_ONES;
            d.to_file = 1'b1;
        end
        return d;
    endfunction

endpackage

// >>> verification/brf_decoder_model.sv
// instruction issuer model standing in for the core decoder
`timescale 1ns/10ps
`default_nettype none

module brf_decoder_model (
    input wire logic sys_clk,
    input wire logic issue,
    input wire logic [15:0] word_in,
    output logic instr_valid,
    output logic [15:0] instr_word
);
    logic valid_q = 1'b0;
    logic [15:0] word_q = 16'h0000;

    // an idle word is inverted each cycle so a stale opcode is never mistaken for a live one
    always @(posedge sys_clk) begin
        valid_q <= issue;
        word_q <= issue ? word_in : ~word_q;
    end

    assign instr_valid = valid_q;
    assign instr_word = word_q;
endmodule
`default_nettype wire

// >>> verification/brf_unit_tb.sv
// self-checking testbench for the byte rotate and fill unit
`timescale 1ns/10ps
`default_nettype none

module brf_unit_tb;
    import brf_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic issue = 1'b0;
    logic [15:0] word_in = 16'h0000;
    logic instr_valid;
    logic [15:0] instr_word;
    logic [7:0] bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h00000000;
    logic bus_write = 1'b0;
    logic bus_read = 1'b0;
    logic [31:0] bus_rdata;
    logic instr_done;
    logic instr_illegal;
    logic [7:0] accumulator;
    logic [7:0] result;
    brf_flags_t flags;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;

    brf_decoder_model brf_decoder_model_inst (.sys_clk(sys_clk), .issue(issue),
        .word_in(word_in), .instr_valid(instr_valid), .instr_word(instr_word));

    brf_unit brf_unit_inst (.sys_clk(sys_clk), .reset_n(reset_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
        .instr_done(instr_done), .instr_illegal(instr_illegal), .accumulator(accumulator),
        .flags(flags), .result(result));

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_write <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge sys_clk);
        bus_write <= 1'b0;
    endtask

    task automatic peek(input logic [11:0] p, input logic [7:0] exp);
        bus_wr(BRF_ADDR_PTR, {20'h0, p});
        @(posedge sys_clk);
        bus_read <= 1'b1;
        bus_addr <= BRF_ADDR_DATA;
        @(posedge sys_clk);
        bus_read <= 1'b0;
        #1;
        chk("operand byte", {24'h0, exp}, bus_rdata);
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge sys_clk);
        bus_read <= 1'b1;
        bus_addr <= a;
        @(posedge sys_clk);
        bus_read <= 1'b0;
        #1;
        chk(what, exp, bus_rdata);
    endtask

    task automatic poke(input logic [11:0] p, input logic [7:0] d);
        bus_wr(BRF_ADDR_PTR, {20'h0, p});
        bus_wr(BRF_ADDR_DATA, {24'h0, d});
    endtask

    // issues one word, then judges the outputs just after the edge on which the design takes it
    task automatic exec(input logic [15:0] w, input logic [7:0] r, input logic [2:0] f);
        @(posedge sys_clk);
        issue <= 1'b1;
        word_in <= w;
        @(posedge sys_clk);
        issue <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk("instr_done", 32'h1, {31'h0, instr_done});
        chk("result", {24'h0, r}, {24'h0, result});
        chk("flags", {29'h0, f}, {29'h0, flags});
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_left();
        bus_wr(BRF_ADDR_BANK, 32'h3);
        bus_wr(BRF_ADDR_FLAGS, 32'h1);
        poke(12'h305, 8'hab);
        poke(12'h005, 8'h11);
        exec({BRF_OP_ROT_LEFT_PLAIN, 2'b11, 8'h05}, 8'h57, 3'h1);
        peek(12'h305, 8'h57);
        peek(12'h005, 8'h11);
        poke(12'h3ff, 8'h00);
        exec({BRF_OP_ROT_LEFT_PLAIN, 2'b11, 8'hff}, 8'h00, 3'h3);
        $display("test rotate left done");
    endtask

    task automatic t_carry();
        bus_wr(BRF_ADDR_FLAGS, 32'h1);
        poke(12'h020, 8'he6);
        poke(12'h320, 8'h00);
        exec({BRF_OP_ROT_RIGHT_CARRY, 2'b00, 8'h20}, 8'hf3, 3'h4);
        chk("accumulator", 32'hf3, {24'h0, accumulator});
        exec({BRF_OP_ROT_RIGHT_CARRY, 2'b00, 8'h20}, 8'h73, 3'h0);
        peek(12'h020, 8'he6);
        $display("test rotate via carry done");
    endtask

    task automatic t_plain();
        bus_wr(BRF_ADDR_FLAGS, 32'h1);
        poke(12'h321, 8'hd7);
        exec({BRF_OP_ROT_RIGHT_PLAIN, 2'b11, 8'h21}, 8'heb, 3'h5);
        exec({BRF_OP_ROT_RIGHT_PLAIN, 2'b01, 8'h21}, 8'hf5, 3'h5);
        chk("accumulator", 32'hf5, {24'h0, accumulator});
        peek(12'h321, 8'heb);
        $display("test rotate right plain done");
    endtask

    task automatic t_fill();
        bus_wr(BRF_ADDR_FLAGS, 32'h6);
        poke(12'h040, 8'h12);
        poke(12'h341, 8'h34);
        exec({BRF_OP_FILL_ONES, 1'b0, 8'h40}, 8'hff, 3'h6);
        exec({BRF_OP_FILL_ONES, 1'b1, 8'h41}, 8'hff, 3'h6);
        peek(12'h040, 8'hff);
        peek(12'h341, 8'hff);
        chk("accumulator", 32'hf5, {24'h0, accumulator});
        $display("test fill ones done");
    endtask

    task automatic t_illegal();
        @(posedge sys_clk);
        issue <= 1'b1;
        word_in <= 16'h0000;
        @(posedge sys_clk);
        issue <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk("instr_illegal", 32'h1, {31'h0, instr_illegal});
        chk("instr_done", 32'h0, {31'h0, instr_done});
        chk("result", 32'hff, {24'h0, result});
        chk("flags", 32'h6, {29'h0, flags});
        @(posedge sys_clk);
        #1;
        chk("instr_illegal", 32'h0, {31'h0, instr_illegal});
        reg_rd(BRF_ADDR_COUNT, 32'h8, "exec count");
        reg_rd(BRF_ADDR_RESULT, 32'hff, "result reg");
        reg_rd(BRF_ADDR_ACC, 32'hf5, "accumulator reg");
        reg_rd(BRF_ADDR_FLAGS, 32'h6, "flags reg");
        reg_rd(BRF_ADDR_BANK, 32'h3, "bank reg");
        @(posedge sys_clk);
        #1;
        chk("idle rdata", 32'h0, bus_rdata);
        $display("test illegal and registers done");
    endtask

    task automatic t_reset();
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk("reset accumulator", {24'h0, BRF_ACC_RESET}, {24'h0, accumulator});
        chk("reset flags", 32'h0, {29'h0, flags});
        chk("reset result", {24'h0, BRF_RESULT_RESET}, {24'h0, result});
        chk("reset instr_done", 32'h0, {31'h0, instr_done});
        chk("reset rdata", 32'h0, bus_rdata);
        reg_rd(BRF_ADDR_COUNT, {16'h0, BRF_COUNT_RESET}, "reset count");
        reg_rd(BRF_ADDR_BANK, 32'h0, "reset bank");
        reg_rd(BRF_ADDR_PTR, 32'h0, "reset pointer");
        poke(12'h077, 8'h80);
        exec({BRF_OP_ROT_LEFT_PLAIN, 2'b01, 8'h77}, 8'h01, 3'h0);
        chk("accumulator", 32'h01, {24'h0, accumulator});
        peek(12'h077, 8'h80);
        $display("test reset in mid-run done");
    endtask

    // ------------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------------
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            end_sim();
        end
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        t_left();
        t_carry();
        t_plain();
        t_fill();
        t_illegal();
        t_reset();
        end_sim();
    end
endmodule
`default_nettype wire
